// >>> hw/spdif_in_defines.svh
/*
 * Constants of the serial audio input stage: framing delays, word
 * widths, slot length and buffer depth.
 * Assumes it is included by its bare name before the package.
 */
// Summary of operation
// - The port accepts left-justified, I2S and right-justified framing.
// - Word width is 16, 18, 20 or 24 bits, and exactly that many are taken.
// - Right-justified: frame clock high is the left slot, low the right.
// - Every data bit is captured on the rising edge of the bit clock.
// - Right-justified MSB delay is 16, 14, 12 or 8 bit clocks by width.
// - That delay assumes 64 bit clocks per frame, LSB ending at the edge.
// - I2S is the default; frame clock low is left, high is right.
// - I2S MSB comes one bit clock after the frame clock transition.
// - Left-justified: frame clock high is left, low is right.
// - Left-justified MSB is the first bit clock after the transition.
`ifndef SPDIF_IN_DEFINES_SVH
`define SPDIF_IN_DEFINES_SVH

// ****************************************************************
// word widths and slot geometry
// ****************************************************************
`define SPDIF_IN_MAX_W      5'd24
`define SPDIF_IN_W16        5'd16
`define SPDIF_IN_W18        5'd18
`define SPDIF_IN_W20        5'd20
`define SPDIF_IN_W24        5'd24
`define SPDIF_IN_FRAME_SCLK 7'd64
`define SPDIF_IN_SLOT_LAST  6'h3f

// ****************************************************************
// bit clocks from frame clock transition to msb
// ****************************************************************
`define SPDIF_IN_LJ_DLY     6'd0
`define SPDIF_IN_I2S_DLY    6'd1
`define SPDIF_IN_RJ_DLY16   6'd16
`define SPDIF_IN_RJ_DLY18   6'd14
`define SPDIF_IN_RJ_DLY20   6'd12
`define SPDIF_IN_RJ_DLY24   6'd8

// ****************************************************************
// crossing and buffering
// ****************************************************************
`define SPDIF_IN_FIFO_DEPTH  2

`endif

// >>> hw/spdif_in_pkg.sv
/*
 * Types of the serial audio input stage.
 * Assumes spdif_in_defines.svh is on the include path.
 */
`include "spdif_in_defines.svh"

package spdif_in_pkg;

  // i2s is code zero so a cleared selector means the default framing
  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_LJ  = 2'b01,
    FMT_RJ  = 2'b10
  } fmt_t;

  typedef enum logic [1:0] {
    WID_16 = 2'b00,
    WID_18 = 2'b01,
    WID_20 = 2'b10,
    WID_24 = 2'b11
  } width_t;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_RUN  = 2'b10
  } link_state_t;

  typedef struct packed {
    logic        left;
    logic [23:0] data;
  } sample_t;

endpackage

// >>> hw/sample_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes both sides run on clk_sys_i; depth is a power of two.
 */
`timescale 1ns/10ps

module sample_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_reg[rd_ptr_reg];

  // ****************************************************************
  // storage, one flop row per entry
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mem_reg[i] <= '0;
      end else if (push && (wr_ptr_reg == AW'(i))) begin
        mem_reg[i] <= in_data_i;
      end
    end
  end

  // ****************************************************************
  // pointers and fill level
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule // sample_fifo

// >>> hw/spdif_serial_in.sv
/*
 * Serial audio input stage: deserialises left/right samples from a
 * bit clock, frame clock and data line, hands them to the encoder.
 * Assumes frame clock and data change away from the bit clock's
 * rising edge, and that fmt_i/width_i only change while idle.
 */
`timescale 1ns/10ps

module spdif_serial_in
  import spdif_in_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPDIF_IN_FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    nrst_i,
  // serial link, sclk_i clocks the link domain
  input  wire logic    sclk_i,
  input  wire logic    lrclk_i,
  input  wire logic    sdata_i,
  // configuration, quasi-static
  input  wire fmt_t    fmt_i,
  input  wire width_t  width_i,
  // samples towards the encoder
  output logic         smp_valid_o,
  input  wire logic    smp_ready_i,
  output sample_t      smp_o,
  // status
  output logic         overrun_o,
  output logic         locked_o
);

  // ****************************************************************
  // link domain reset
  // ****************************************************************
  // asserted at once, released on the bit clock
  logic [1:0] lrst_sync_reg;
  logic       lrst_n;

  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lrst_sync_reg <= 2'h0;
    end else begin
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
    end
  end

  assign lrst_n = lrst_sync_reg[1];

  // ****************************************************************
  // configuration into the link domain
  // ****************************************************************
  fmt_t   fmt_meta_reg;
  fmt_t   fmt_reg;
  width_t wid_meta_reg;
  width_t wid_reg;

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      fmt_meta_reg <= FMT_I2S;
      fmt_reg      <= FMT_I2S;
      wid_meta_reg <= WID_16;
      wid_reg      <= WID_16;
    end else begin
      fmt_meta_reg <= fmt_i;
      fmt_reg      <= fmt_meta_reg;
      wid_meta_reg <= width_i;
      wid_reg      <= wid_meta_reg;
    end
  end

  // ****************************************************************
  // slot geometry for the active format and width
  // ****************************************************************
  logic [4:0] wbits;
  logic [5:0] start_idx;

  always_comb begin
    case (wid_reg)
      WID_16:  wbits = `SPDIF_IN_W16;
      WID_18:  wbits = `SPDIF_IN_W18;
      WID_20:  wbits = `SPDIF_IN_W20;
      WID_24:  wbits = `SPDIF_IN_W24;
      default: wbits = `SPDIF_IN_W16;
    endcase
  end

  // rj delays assume 64 bit clocks per frame so the lsb lands in the
  // last slot before the next transition; in longer frames the word is taken too early
  always_comb begin
    case (fmt_reg)
      FMT_LJ:  start_idx = `SPDIF_IN_LJ_DLY;
      FMT_RJ: begin
        case (wid_reg)
          WID_16:  start_idx = `SPDIF_IN_RJ_DLY16;
          WID_18:  start_idx = `SPDIF_IN_RJ_DLY18;
          WID_20:  start_idx = `SPDIF_IN_RJ_DLY20;
          WID_24:  start_idx = `SPDIF_IN_RJ_DLY24;
          default: start_idx = `SPDIF_IN_RJ_DLY16;
        endcase
      end
      FMT_I2S: start_idx = `SPDIF_IN_I2S_DLY;
      default: start_idx = `SPDIF_IN_I2S_DLY;
    endcase
  end

  // ****************************************************************
  // frame clock edge and bit slot counter
  // ****************************************************************
  link_state_t state_reg;
  link_state_t state_next;
  logic        lr_prev_reg;
  logic        lr_seen_reg;
  logic [5:0]  slot_reg;
  logic [5:0]  slot_next;
  logic        lr_edge;
  logic        active;

  // lrclk_i and sdata_i are synchronous to sclk_i: sampled directly
  // first sample after reset only primes the compare, so a frame
  // clock parked high is not mistaken for a transition
  assign lr_edge = lr_seen_reg && (lrclk_i != lr_prev_reg);
  assign active  = (state_reg == ST_RUN) || lr_edge;

  always_comb begin
    if (lr_edge) begin
      slot_next = 6'h00;
    end else if (slot_reg == `SPDIF_IN_SLOT_LAST) begin
      slot_next = slot_reg;
    end else begin
      slot_next = slot_reg + 6'h01;
    end
  end

  // hunting drops bits until the first transition, so the first
  // word out is never a partial one
  always_comb begin
    case (state_reg)
      ST_HUNT: state_next = lr_edge ? ST_RUN : ST_HUNT;
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_HUNT;
    endcase
  end

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      state_reg <= ST_HUNT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      lr_prev_reg <= 1'b0;
      lr_seen_reg <= 1'b0;
      slot_reg    <= 6'h00;
    end else begin
      lr_prev_reg <= lrclk_i;
      lr_seen_reg <= 1'b1;
      slot_reg    <= slot_next;
    end
  end

  // ****************************************************************
  // shifter
  // ****************************************************************
  logic [23:0] shift_reg;
  logic [4:0]  bits_reg;
  logic        chan_reg;
  logic        first_bit;
  logic        more_bit;
  logic        word_done;
  logic        left_now;
  logic [23:0] shift_next;

  // polarity differs between framings
  always_comb begin
    case (fmt_reg)
      FMT_I2S: left_now = ~lrclk_i;
      FMT_LJ:  left_now = lrclk_i;
      FMT_RJ:  left_now = lrclk_i;
      default: left_now = ~lrclk_i;
    endcase
  end

  assign first_bit  = active && (slot_next == start_idx);
  assign more_bit   = active && !first_bit && !lr_edge &&
                      (bits_reg != 5'h00) && (bits_reg < wbits);
  assign shift_next = {shift_reg[22:0], sdata_i};
  assign word_done  = more_bit && ((bits_reg + 5'h01) == wbits);

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      shift_reg <= 24'h000000;
      bits_reg  <= 5'h00;
      chan_reg  <= 1'b0;
    end else if (first_bit) begin
      shift_reg <= {23'h000000, sdata_i};
      bits_reg  <= 5'h01;
      chan_reg  <= left_now;
    end else if (more_bit) begin
      shift_reg <= shift_next;
      bits_reg  <= bits_reg + 5'h01;
    end else if (lr_edge || bits_reg >= wbits) begin
      // a transition mid-word abandons it
      bits_reg <= 5'h00;
    end
  end

  // ****************************************************************
  // finished word, held for the system side
  // ****************************************************************
  // a word stays put for at least eight bit clocks, far longer than
  // the three system cycles the toggle needs to cross
  sample_t word_reg;
  logic    word_tgl_reg;

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      word_reg     <= '0;
      word_tgl_reg <= 1'b0;
    end else if (word_done) begin
      word_reg.left <= chan_reg;
      word_reg.data <= shift_next;
      word_tgl_reg  <= ~word_tgl_reg;
    end
  end

  // ****************************************************************
  // crossing into the system domain
  // ****************************************************************
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_seen_reg;
  logic lock_meta_reg;
  logic lock_sync_reg;
  logic new_word;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_meta_reg  <= 1'b0;
      tgl_sync_reg  <= 1'b0;
      tgl_seen_reg  <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      tgl_meta_reg  <= word_tgl_reg;
      tgl_sync_reg  <= tgl_meta_reg;
      tgl_seen_reg  <= tgl_sync_reg;
      lock_meta_reg <= (state_reg == ST_RUN);
      lock_sync_reg <= lock_meta_reg;
    end
  end

  assign new_word = tgl_sync_reg ^ tgl_seen_reg;
  assign locked_o = lock_sync_reg;

  // ****************************************************************
  // pending word and buffer
  // ****************************************************************
  // the audio source cannot be stalled; the pending stage waits on
  // a full buffer and a word arriving meanwhile is counted as lost
  sample_t pend_reg;
  logic    pend_valid_reg;
  logic    fifo_in_ready;
  logic    accepted;
  logic    load;
  logic    overrun_reg;

  assign accepted = pend_valid_reg && fifo_in_ready;
  assign load     = new_word && (!pend_valid_reg || accepted);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_reg       <= '0;
      pend_valid_reg <= 1'b0;
    end else if (load) begin
      pend_reg       <= word_reg;
      pend_valid_reg <= 1'b1;
    end else if (accepted) begin
      pend_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= new_word && pend_valid_reg && !accepted;
    end
  end

  assign overrun_o = overrun_reg;

  sample_fifo #(
    .W     ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (pend_valid_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_reg),
    .out_valid_o (smp_valid_o),
    .out_ready_i (smp_ready_i),
    .out_data_o  (smp_o)
  );

endmodule // spdif_serial_in

// >>> verification/spdif_serial_in_sva.sv
/*
 * Checker of the serial audio input stage, encoder-side ports.
 * Assumes it is bound to spdif_serial_in from the bench top file.
 */
`timescale 1ns/10ps

module spdif_serial_in_sva
  import spdif_in_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input wire logic   clk_sys_i,
  input wire logic   nrst_i,
  // configuration
  input wire width_t width_i,
  // sample hand-over and status
  input wire logic   smp_valid_o,
  input wire logic   smp_ready_i,
  input wire sample_t smp_o,
  input wire logic   overrun_o,
  input wire logic   locked_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_reset_quiet: assert property ($rose(nrst_i) |->
    !smp_valid_o && !overrun_o && !locked_o)
    else $error("outputs not quiet after reset");
  a_hold_valid: assert property (smp_valid_o && !smp_ready_i |=>
    smp_valid_o) else $error("sample withdrawn before pop");
  a_hold_data: assert property (smp_valid_o && !smp_ready_i |=>
    $stable(smp_o)) else $error("sample changed before pop");
  a_overrun_pulse: assert property (overrun_o |=> !overrun_o)
    else $error("overrun longer than one cycle");
  a_overrun_full: assert property (overrun_o |->
    smp_valid_o && $past(smp_valid_o, 2))
    else $error("overrun while buffer not holding words");
  a_unlocked_empty: assert property (!locked_o |-> !smp_valid_o)
    else $error("sample before first frame edge");
  a_locked_stays: assert property (locked_o |=> locked_o [*4])
    else $error("lock lost without reset");
  a_width_clear: assert property (smp_valid_o |->
    (width_i != WID_16 || smp_o.data[23:16] == 8'h00) &&
    (width_i != WID_18 || smp_o.data[23:18] == 6'h00) &&
    (width_i != WID_20 || smp_o.data[23:20] == 4'h0))
    else $error("bits above word width not zero");
endmodule // spdif_serial_in_sva

// >>> verification/audio_src_model.sv
/*
 * Serial audio source: makes bit clock, frame clock and data.
 * Assumes the bench calls its tasks; the bit clock idles low
 * between frames.
 */
`timescale 1ns/10ps

module audio_src_model
  import spdif_in_pkg::*;
(
  // serial link
  output logic sclk_o,
  output logic lrclk_o,
  output logic sdata_o
);
  initial begin
    sclk_o  = 1'b0;
    lrclk_o = 1'b0;
    sdata_o = 1'b0;
  end

  // changes made on the falling edge, so setup and hold are half a period
  task automatic put(input logic lr, input logic d);
    lrclk_o = lr;
    sdata_o = d;
    #62.5 sclk_o = 1'b1;
    #62.5 sclk_o = 1'b0;
  endtask

  // unused slots carry flipping data, never the last bit held
  task automatic tick(input int n);
    repeat (n) put(lrclk_o, ~sdata_o);
  endtask

  task automatic send_half(input fmt_t f, input width_t w, input logic lr,
                           input logic [23:0] word);
    int n;
    int s;
    n = (w == WID_24) ? 24 : 16 + 2 * int'(w);
    s = (f == FMT_LJ) ? 0 : (f == FMT_I2S) ? 1 : 32 - n;
    for (int k = 0; k < 32; k++) begin
      if (k >= s && k < s + n) begin
        put(lr, word[n-1-(k-s)]);
      end else begin
        put(lr, ~sdata_o);
      end
    end
  endtask

  // preamble keeps the right level so no edge is made before the frame
  task automatic send_frame(input fmt_t f, input width_t w,
                            input logic [23:0] lw, input logic [23:0] rw);
    logic lv;
    lv = (f == FMT_I2S) ? 1'b0 : 1'b1;
    repeat (4) put(~lv, ~sdata_o);
    send_half(f, w, lv, lw);
    send_half(f, w, ~lv, rw);
  endtask
endmodule // audio_src_model

// >>> verification/tb_top.sv
/*
 * Testbench of the serial audio input stage: every framing and width,
 * then a stalled encoder that overruns the buffer.
 * Assumes the design, package and checker are compiled before it.
 */
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  miscompares++; $display("wrong value %s expected %0h seen %0h", \
  nm, ex, got); end end

module tb_top
  import spdif_in_pkg::*;
;
  logic    clk_sys_i;
  logic    nrst_i;
  logic    smp_ready_i;
  logic    smp_valid_o;
  logic    overrun_o;
  logic    locked_o;
  logic    sclk;
  logic    lrclk;
  logic    sdata;
  fmt_t    fmt;
  width_t  width;
  sample_t smp;
  int      miscompares;
  int      checked;
  int      ovr_seen;

  audio_src_model src (.sclk_o(sclk), .lrclk_o(lrclk), .sdata_o(sdata));

  spdif_serial_in dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .lrclk_i(lrclk), .sdata_i(sdata), .fmt_i(fmt), .width_i(width),
    .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_o(smp),
    .overrun_o(overrun_o), .locked_o(locked_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (overrun_o === 1'b1) ovr_seen++;
  end

  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // config is only allowed to move while reset is held
  task automatic restart(input fmt_t f, input width_t w);
    @(posedge clk_sys_i);
    #1 nrst_i = 1'b0;
    fmt = f;
    width = w;
    smp_ready_i = 1'b0;
    src.tick(2);
    repeat (4) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    `CHK("locked", 1'b0, locked_o)
    `CHK("valid", 1'b0, smp_valid_o)
  endtask

  task automatic take(input logic lft, input logic [23:0] d);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (smp_valid_o !== 1'b1 && n < 600);
    `CHK("valid", 1'b1, smp_valid_o)
    `CHK("tag", lft, smp.left)
    `CHK("data", d, smp.data)
    smp_ready_i = 1'b1;
    @(posedge clk_sys_i);
    #1 smp_ready_i = 1'b0;
  endtask

  function automatic logic [23:0] cut(input width_t w, input logic [23:0] d);
    logic [24:0] m;
    m = (25'h1 << ((w == WID_24) ? 24 : 16 + 2 * int'(w))) - 25'h1;
    return d & m[23:0];
  endfunction

  task automatic one_frame(input fmt_t f, input width_t w);
    logic [23:0] l;
    logic [23:0] r;
    l = 24'hc3a596 ^ {20'h0, f, w};
    r = 24'h5b6e17 ^ {20'h0, w, f};
    restart(f, w);
    fork
      src.send_frame(f, w, l, r);
      begin
        take(1'b1, cut(w, l));
        take(1'b0, cut(w, r));
      end
    join
    `CHK("locked", 1'b1, locked_o)
  endtask

  // three words fit in buffer and pending stage, the fourth is lost
  task automatic stall_test;
    restart(FMT_LJ, WID_24);
    ovr_seen = 0;
    src.send_frame(FMT_LJ, WID_24, 24'h800001, 24'h7ffffe);
    src.send_frame(FMT_LJ, WID_24, 24'h123456, 24'hfedcba);
    repeat (10) @(posedge clk_sys_i);
    #1;
    `CHK("overrun", 1, ovr_seen)
    take(1'b1, 24'h800001);
    take(1'b0, 24'h7ffffe);
    take(1'b1, 24'h123456);
    repeat (8) @(posedge clk_sys_i);
    #1;
    `CHK("valid", 1'b0, smp_valid_o)
  endtask

  initial begin
    nrst_i = 1'b0;
    smp_ready_i = 1'b0;
    fmt = FMT_I2S;
    width = WID_16;
    miscompares = 0;
    checked = 0;
    ovr_seen = 0;
    repeat (4) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 4; w++) begin
        one_frame(fmt_t'(f), width_t'(w));
      end
    end
    stall_test;
    conclude;
  end

  initial begin
    #1_000_000;
    miscompares++;
    conclude;
  end
endmodule // tb_top

bind spdif_serial_in spdif_serial_in_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .width_i(width_i),
  .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_o(smp_o),
  .overrun_o(overrun_o), .locked_o(locked_o)
);
